// ===== hw/adc_conversion_sequencer.sv
`timescale 1ns/1ns
// Contract
// - with power gate clear, writing start begins one conversion; start clears on completion
// - channel changed mid-conversion applies only after the running conversion ends
// - auto trigger enable turns on triggering from the selected source
// - rising edge of selected trigger resets prescaler and starts a conversion
// - trigger still high at completion or edges during conversion are ignored
// - done flag sets regardless of interrupt enables; flag sources need clearing (free running here restarts with the done flag left set)
// - done flag as source gives free running; first conversion started by start bit
// - start write still works under auto trigger; start reads one while converting
// - prescaler divides cpu clock per select, held reset while enable is zero
// - start-bit conversion begins at next rising converter clock edge
// - normal conversion is 13 converter cycles, first after enable is 25
// - sample-and-hold at 1.5 cycles normally, 13.5 for first conversion
// - completion stores result, sets done flag, clears start in single mode
// - auto triggered: sample at 2 cycles after edge, total 13.5 cycles
// - free running restarts right after completion with start kept high
// - selections buffered: copied until start, locked, resumed in last cycle
// - free running channel change affects only conversions after the current one
// - selections do not take effect while enable is clear
// - each conversion yields a 10-bit result in low and high bytes
module adc_conversion_sequencer
    import adcsq_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // trigger pins
    input  wire logic [NUM_TRIG-1:0]   trigIn,
    // analog core
    input  wire logic [RES_W-1:0]      coreResult,
    output logic                       convBusy,
    output logic                       sampleHold,
    output logic                       convDone,
    output logic      [CH_W-1:0]       activeChannel,
    output logic      [RF_W-1:0]       activeRef
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        adcsq_phase_t          phase;
        adcsq_mode_t           mode;
        logic                  enable;
        logic                  autoEn;
        logic                  doneFlag;
        logic                  gate;
        logic                  firstPend;
        logic [PS_W-1:0]       psSel;
        logic [TS_W-1:0]       tsSel;
        logic [CH_W-1:0]       selCh;
        logic [RF_W-1:0]       selRef;
        logic [CH_W-1:0]       actCh;
        logic [RF_W-1:0]       actRef;
        logic [HALF_W-1:0]     halfCnt;
        logic [PRE_W-1:0]      presc;
        logic [NUM_TRIG-1:0]   trigS1;
        logic [NUM_TRIG-1:0]   trigS2;
        logic                  trigPrev;
        logic [RES_W-1:0]      result;
        logic                  sh;
        logic                  done;
        logic [31:0]           rdata;
    } adcsq_state_t;

    adcsq_state_t state_ff;
    adcsq_state_t nxt_state;

    logic [PRE_W-1:0]  divTop;
    logic              fullTick;
    logic              halfTick;
    logic              trigLevel;
    logic              trigEdge;
    logic [HALF_W-1:0] convLen;
    logic [HALF_W-1:0] shPoint;
    logic              convEnd;
    logic              resumeWin;
    logic              freeRun;
    logic              wrEn;
    logic              rdSetup;
    logic              mapped;
    logic              startWrite;
    logic              canStart;

    // -------------------------------------------------------------------
    // prescaler taps and trigger edge
    // -------------------------------------------------------------------
    assign divTop    = PRE_W'((1 << ((state_ff.psSel < PS_MIN_SHIFT) ? PS_MIN_SHIFT : state_ff.psSel)) - 1);
    assign fullTick  = (state_ff.presc == divTop);
    assign halfTick  = fullTick || (state_ff.presc == (divTop >> 1));
    assign trigLevel = state_ff.trigS2[state_ff.tsSel];
    assign trigEdge  = trigLevel && !state_ff.trigPrev;
    assign freeRun   = state_ff.autoEn && (state_ff.tsSel == TS_FREE_RUN);

    always_comb
    begin
        unique case (state_ff.mode)
            MD_FIRST:
            begin
                convLen = HALF_FIRST;
                shPoint = SHH_FIRST;
            end
            MD_AUTO:
            begin
                convLen = HALF_AUTO;
                shPoint = SHH_AUTO;
            end
            default:
            begin
                convLen = HALF_NORMAL;
                shPoint = SHH_NORMAL;
            end
        endcase
    end

    // an aborting disable or power gate in the last half tick must not flag completion
    assign convEnd   = (state_ff.phase == PH_CONV) && canStart && halfTick && (state_ff.halfCnt == convLen - 6'h01);
    assign resumeWin = (state_ff.halfCnt >= convLen - 6'h02);

    // -------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------
    assign mapped     = (paddr == OFF_CTRL_A) || (paddr == OFF_CTRL_B) || (paddr == OFF_SEL)
                     || (paddr == OFF_RESULT) || (paddr == OFF_ACTIVE);
    assign wrEn       = psel && penable && pwrite && mapped;
    assign rdSetup    = psel && !penable && !pwrite;
    assign startWrite = wrEn && (paddr == OFF_CTRL_A) && pwdata[CA_START];
    assign canStart   = state_ff.enable && !state_ff.gate;
    assign pready     = penable;
    assign pslverr    = psel && penable && !mapped;

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb
    begin
        nxt_state          = state_ff;
        nxt_state.sh       = 1'b0;
        nxt_state.done     = 1'b0;
        nxt_state.trigS1   = trigIn;
        nxt_state.trigS2   = state_ff.trigS1;
        nxt_state.trigPrev = trigLevel;

        if (!state_ff.enable)
            nxt_state.presc = '0;
        else if (fullTick)
            nxt_state.presc = '0;
        else
            nxt_state.presc = state_ff.presc + 7'h01;

        unique case (state_ff.phase)
            PH_IDLE:
            begin
                if (canStart && state_ff.autoEn && !freeRun && trigEdge)
                begin
                    nxt_state.phase   = PH_CONV;
                    nxt_state.mode    = state_ff.firstPend ? MD_FIRST : MD_AUTO;
                    nxt_state.halfCnt = '0;
                    nxt_state.presc   = '0;
                    nxt_state.firstPend = 1'b0;
                end
                // start write launches a conversion, a single one or the first of a free running series
                else if (canStart && startWrite)
                    nxt_state.phase = PH_WAIT;
            end
            PH_WAIT:
            begin
                // begin on next converter clock rising edge
                if (!canStart)
                    nxt_state.phase = PH_IDLE;
                else if (fullTick)
                begin
                    nxt_state.phase     = PH_CONV;
                    nxt_state.mode      = state_ff.firstPend ? MD_FIRST : MD_NORMAL;
                    nxt_state.halfCnt   = '0;
                    nxt_state.firstPend = 1'b0;
                end
            end
            PH_CONV:
            begin
                // start writes are not looked at here
                if (!canStart)
                    nxt_state.phase = PH_IDLE;
                else if (convEnd)
                begin
                    nxt_state.result = coreResult;
                    nxt_state.done   = 1'b1;
                    if (freeRun)
                    begin
                        nxt_state.mode    = MD_NORMAL;
                        nxt_state.halfCnt = '0;
                    end
                    else
                        nxt_state.phase = PH_IDLE;
                end
                else if (halfTick)
                begin
                    // length counted in half converter cycles
                    nxt_state.halfCnt = state_ff.halfCnt + 6'h01;
                    if (state_ff.halfCnt + 6'h01 == shPoint)
                        nxt_state.sh = 1'b1;
                end
            end
            default:
                nxt_state.phase = PH_IDLE;
        endcase

        if (state_ff.enable && (state_ff.phase != PH_CONV || resumeWin))
        begin
            nxt_state.actCh  = state_ff.selCh;
            nxt_state.actRef = state_ff.selRef;
        end

        if (!state_ff.enable)
            nxt_state.firstPend = 1'b1;

        // software writes
        if (wrEn)
        begin
            unique case (paddr)
                OFF_CTRL_A:
                begin
                    nxt_state.enable = pwdata[CA_ENABLE];
                    nxt_state.autoEn = pwdata[CA_AUTO];
                    nxt_state.psSel  = pwdata[CA_PS_LSB +: PS_W];
                    if (pwdata[CA_DONE])
                        nxt_state.doneFlag = 1'b0;
                end
                OFF_CTRL_B:
                begin
                    nxt_state.tsSel = pwdata[CB_TS_LSB +: TS_W];
                    nxt_state.gate  = pwdata[CB_GATE];
                end
                OFF_SEL:
                begin
                    nxt_state.selCh  = pwdata[SEL_CH_LSB +: CH_W];
                    nxt_state.selRef = pwdata[SEL_RF_LSB +: RF_W];
                end
                default:
                    nxt_state.rdata = state_ff.rdata;
            endcase
        end

        // done flag set wins over clear
        if (convEnd)
            nxt_state.doneFlag = 1'b1;

        // read data captured in the setup phase
        if (rdSetup)
        begin
            nxt_state.rdata = '0;
            unique case (paddr)
                OFF_CTRL_A:
                begin
                    nxt_state.rdata[CA_ENABLE]             = state_ff.enable;
                    nxt_state.rdata[CA_START]              = (state_ff.phase != PH_IDLE);
                    nxt_state.rdata[CA_AUTO]               = state_ff.autoEn;
                    nxt_state.rdata[CA_DONE]               = state_ff.doneFlag;
                    nxt_state.rdata[CA_PS_LSB +: PS_W]     = state_ff.psSel;
                end
                OFF_CTRL_B:
                begin
                    nxt_state.rdata[CB_TS_LSB +: TS_W]     = state_ff.tsSel;
                    nxt_state.rdata[CB_GATE]               = state_ff.gate;
                end
                OFF_SEL:
                begin
                    nxt_state.rdata[SEL_CH_LSB +: CH_W]    = state_ff.selCh;
                    nxt_state.rdata[SEL_RF_LSB +: RF_W]    = state_ff.selRef;
                end
                OFF_RESULT:
                    // ten result bits, low byte then high bits
                    nxt_state.rdata[RES_W-1:0]             = state_ff.result;
                OFF_ACTIVE:
                begin
                    nxt_state.rdata[SEL_CH_LSB +: CH_W]    = state_ff.actCh;
                    nxt_state.rdata[SEL_RF_LSB +: RF_W]    = state_ff.actRef;
                end
                default:
                    nxt_state.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff           <= '0;
            state_ff.phase     <= PH_IDLE;
            state_ff.mode      <= MD_NORMAL;
            state_ff.firstPend <= 1'b1;
        end
        else
            state_ff <= nxt_state;
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign prdata        = state_ff.rdata;
    assign convBusy      = (state_ff.phase == PH_CONV);
    assign sampleHold    = state_ff.sh;
    assign convDone      = state_ff.done;
    // core sees only the copied selection
    assign activeChannel = state_ff.actCh;
    assign activeRef     = state_ff.actRef;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    sequence seq_conv_end;
        convEnd;
    endsequence

    sequence seq_single_end;
        convEnd && !freeRun;
    endsequence

    chk_done_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        seq_conv_end |=> state_ff.doneFlag && convDone)
        else $error("done flag not set on completion");

    chk_single_clears_start: assert property (@(posedge clk) disable iff (!rst_n)
        seq_single_end |=> state_ff.phase == PH_IDLE && !convBusy)
        else $error("start not cleared after single conversion");

    chk_free_run_restart: assert property (@(posedge clk) disable iff (!rst_n)
        seq_conv_end and (freeRun && canStart) |=> convBusy && state_ff.halfCnt == 6'h00)
        else $error("free running did not restart");

    chk_sel_locked: assert property (@(posedge clk) disable iff (!rst_n)
        convBusy && !resumeWin |=> $stable(activeChannel) && $stable(activeRef))
        else $error("selection changed while locked");

    chk_prescaler_held: assert property (@(posedge clk) disable iff (!rst_n)
        !state_ff.enable |=> state_ff.presc == 7'h00)
        else $error("prescaler ran while disabled");

    chk_gate_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff.phase == PH_IDLE && state_ff.gate |=> state_ff.phase == PH_IDLE)
        else $error("conversion began with power gate set");

    chk_trig_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        convBusy && !convEnd && trigEdge |=> state_ff.halfCnt >= $past(state_ff.halfCnt))
        else $error("trigger restarted a running conversion");

    chk_start_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        convBusy && !convEnd && startWrite && canStart |=> convBusy && $stable(state_ff.mode))
        else $error("start write disturbed conversion");

    chk_wait_on_tick: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff.phase == PH_WAIT && canStart && !fullTick |=> state_ff.phase == PH_WAIT)
        else $error("conversion began off the converter clock edge");

endmodule

// ===== hw/adcsq_pkg.sv
package adcsq_pkg;

    // -------------------------------------------------------------------
    // register map (byte addresses)
    // -------------------------------------------------------------------
    localparam int          ADDR_W       = 5;
    localparam logic [4:0]  OFF_CTRL_A   = 5'h00;
    localparam logic [4:0]  OFF_CTRL_B   = 5'h04;
    localparam logic [4:0]  OFF_SEL      = 5'h08;
    localparam logic [4:0]  OFF_RESULT   = 5'h0C;
    localparam logic [4:0]  OFF_ACTIVE   = 5'h10;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int CA_ENABLE  = 7;
    localparam int CA_START   = 6;
    localparam int CA_AUTO    = 5;
    localparam int CA_DONE    = 4;
    localparam int CA_PS_LSB  = 0;
    localparam int CB_TS_LSB  = 0;
    localparam int CB_GATE    = 7;
    localparam int SEL_CH_LSB = 0;
    localparam int SEL_RF_LSB = 6;
    localparam int PS_W       = 3;
    localparam int TS_W       = 3;
    localparam int CH_W       = 4;
    localparam int RF_W       = 2;
    localparam int RES_W      = 10;
    localparam int NUM_TRIG   = 8;
    localparam int HALF_W     = 6;
    localparam int PRE_W      = 7;

    // -------------------------------------------------------------------
    // timing, in converter clock cycles and as half-cycle counts
    // -------------------------------------------------------------------
    localparam real CYC_NORMAL    = 13.0;
    localparam real CYC_FIRST     = 25.0;
    localparam real CYC_AUTO      = 13.5;
    localparam real SH_NORMAL     = 1.5;
    localparam real SH_FIRST      = 13.5;
    localparam real SH_AUTO       = 2.0;
    localparam logic [5:0] HALF_NORMAL = 6'(int'(CYC_NORMAL * 2.0));
    localparam logic [5:0] HALF_FIRST  = 6'(int'(CYC_FIRST * 2.0));
    localparam logic [5:0] HALF_AUTO   = 6'(int'(CYC_AUTO * 2.0));
    localparam logic [5:0] SHH_NORMAL  = 6'(int'(SH_NORMAL * 2.0));
    localparam logic [5:0] SHH_FIRST   = 6'(int'(SH_FIRST * 2.0));
    localparam logic [5:0] SHH_AUTO    = 6'(int'(SH_AUTO * 2.0));
    localparam logic [2:0] TS_FREE_RUN = 3'h0;
    localparam logic [2:0] PS_MIN_SHIFT = 3'h1;

    typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_CONV} adcsq_phase_t;
    typedef enum logic [1:0] {MD_NORMAL, MD_FIRST, MD_AUTO} adcsq_mode_t;

endpackage

// ===== sim/adcsq_core_model.sv
`timescale 1ns/1ns
// analog core stand-in: the code is only valid from the sample point
// until the cycle after completion, and it shows changing garbage otherwise
module adcsq_core_model
    import adcsq_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // control from the sequencer
    input  wire logic              sampleHold,
    input  wire logic              convDone,
    input  wire logic [CH_W-1:0]   activeChannel,
    input  wire logic [RF_W-1:0]   activeRef,
    // conversion value
    output logic      [RES_W-1:0]  coreResult
);
    logic [RES_W-1:0] heldVal_ff;
    logic             valid_ff;
    logic [RES_W-1:0] noise_ff;

    // 10-bit code taken from the locked selection at the sample point
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            heldVal_ff <= 10'h000;
            valid_ff   <= 1'b0;
            noise_ff   <= 10'h155;
        end
        else
        begin
            noise_ff <= noise_ff + 10'h2B7;
            if (sampleHold)
            begin
                heldVal_ff <= {activeRef, activeChannel, 4'hA};
                valid_ff   <= 1'b1;
            end
            else if (convDone)
            begin
                valid_ff <= 1'b0;
            end
        end
    end

    assign coreResult = valid_ff ? heldVal_ff : noise_ff;
endmodule

// ===== sim/adc_conversion_sequencer_test.sv
`timescale 1ns/1ns
module adc_conversion_sequencer_test;
    import adcsq_pkg::*;
    logic                clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic                convBusy, sampleHold, convDone, busyPrev, err;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic [NUM_TRIG-1:0] trigIn;
    logic [RES_W-1:0]    coreResult;
    logic [CH_W-1:0]     activeChannel, ch, ch2;
    logic [RF_W-1:0]     activeRef, rf;
    int                  n_fail, num_checks, seed, cycles, len, sh, startCnt, doneCnt, k, s0;

    adc_conversion_sequencer uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigIn(trigIn),
        .coreResult(coreResult), .convBusy(convBusy), .sampleHold(sampleHold), .convDone(convDone),
        .activeChannel(activeChannel), .activeRef(activeRef));
    adcsq_core_model core (.clk(clk), .rst_n(rst_n), .sampleHold(sampleHold), .convDone(convDone),
        .activeChannel(activeChannel), .activeRef(activeRef), .coreResult(coreResult));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        busyPrev <= convBusy;
        if (convBusy === 1'b1 && busyPrev !== 1'b1) startCnt++;
        if (convDone === 1'b1) doneCnt++;
        cycles++;
        if (cycles > 30000)
        begin
            n_fail++;
            finish_test();
        end
    end

    // expected cycle count: half converter cycles times clocks per half cycle
    function automatic logic [31:0] exp_cyc(input logic [5:0] h, input int ps);
        return 32'(h) << (ps - 1);
    endfunction

    function automatic logic [31:0] sel_word(input logic [1:0] r, input logic [3:0] c);
        return {24'h000000, r, 2'b00, c};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic measure();
        int n;
        n = 0;
        len = 0;
        sh = -1;
        while (convBusy !== 1'b1 && n < 9000)
        begin
            @(negedge clk);
            n++;
        end
        while (convBusy === 1'b1 && len < 9000)
        begin
            if (sampleHold === 1'b1 && sh < 0) sh = len;
            len++;
            @(negedge clk);
        end
    endtask

    task automatic idle_no_start(input int n);
        s0 = startCnt;
        repeat (n) @(posedge clk);
    endtask

    task automatic finish_test();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, trigIn} = '0;
        {n_fail, num_checks, cycles, startCnt, doneCnt} = '0;
        seed = 32'h62e4;
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, OFF_CTRL_A, 0);
        chk(rd, 0);
        apb(0, OFF_RESULT, 0);
        chk(rd, 0);
        apb(0, 5'h14, 0);
        chk({rd[30:0], err}, 1);
        // first conversion after enable, at a legal converter clock rate
        ch = 4'($random(seed));
        rf = 2'($random(seed));
        apb(1, OFF_SEL, sel_word(rf, ch));
        apb(1, OFF_CTRL_A, 32'h87);
        apb(1, OFF_CTRL_A, 32'hC7);
        fork
            measure();
            begin
                repeat (200) @(posedge clk);
                apb(0, OFF_CTRL_A, 0);
                chk(rd[CA_START], 1);
            end
        join
        chk(len, exp_cyc(HALF_FIRST, 7));
        chk(sh, exp_cyc(SHH_FIRST, 7));
        apb(0, OFF_CTRL_A, 0);
        chk(rd, 32'h97);
        apb(0, OFF_RESULT, 0);
        chk(rd, {rf, ch, 4'hA});
        // normal conversion with selection and start rewritten mid-way
        apb(1, OFF_CTRL_A, 32'h91);
        ch2 = ~ch;
        apb(1, OFF_CTRL_A, 32'hC1);
        fork
            measure();
            begin
                wait (convBusy === 1'b1);
                apb(1, OFF_SEL, sel_word(rf, ch2));
                apb(1, OFF_CTRL_A, 32'hC1);
                chk(activeChannel, ch);
            end
        join
        chk(len, exp_cyc(HALF_NORMAL, 1));
        chk(sh, exp_cyc(SHH_NORMAL, 1));
        apb(0, OFF_RESULT, 0);
        chk(rd, {rf, ch, 4'hA});
        chk(activeChannel, ch2);
        chk(activeRef, rf);
        // selection frozen while disabled; reference switched, next result discarded
        apb(1, OFF_CTRL_A, 32'h11);
        apb(1, OFF_SEL, sel_word(~rf, ch));
        repeat (10) @(posedge clk);
        chk(activeChannel, ch2);
        chk(activeRef, rf);
        // power gate blocks a start
        apb(1, OFF_CTRL_B, 32'h80);
        apb(1, OFF_CTRL_A, 32'h81);
        idle_no_start(0);
        apb(1, OFF_CTRL_A, 32'hC1);
        repeat (80) @(posedge clk);
        chk(startCnt, s0);
        apb(1, OFF_CTRL_A, 32'h01);
        apb(1, OFF_CTRL_B, 32'h00);
        apb(1, OFF_CTRL_A, 32'h81);
        apb(1, OFF_CTRL_A, 32'hC1);
        measure();
        chk(len, exp_cyc(HALF_FIRST, 1));
        // auto trigger from every pin source
        for (k = 1; k < NUM_TRIG; k++)
        begin
            apb(1, OFF_CTRL_A, 32'hB1);
            apb(1, OFF_CTRL_B, k);
            idle_no_start(0);
            trigIn <= 8'($random(seed)) & ~(8'h01 << k);
            repeat (20) @(posedge clk);
            chk(startCnt, s0);
            trigIn[k] <= 1'b1;
            measure();
            chk(len, exp_cyc(HALF_AUTO, 1));
            chk(sh, exp_cyc(SHH_AUTO, 1));
            idle_no_start(80);
            chk(startCnt, s0);
            trigIn <= '0;
        end
        // free running from the done flag, flag never cleared
        apb(1, OFF_CTRL_B, TS_FREE_RUN);
        apb(1, OFF_CTRL_A, 32'hE1);
        k = doneCnt;
        repeat (150) @(posedge clk);
        chk((doneCnt - k) >= 4 && (doneCnt - k) <= 6, 1);
        apb(0, OFF_CTRL_A, 0);
        chk({rd[CA_START], rd[CA_DONE]}, 2'b11);
        apb(1, OFF_CTRL_A, 32'h00);
        finish_test();
    end
endmodule
